// *** rtl/sfc_pkg.sv ***
// Shared constants, frame check function and state record of the serial control block
package sfc_pkg;

   // Register indices; byte address on the register bus is four times the index
   localparam logic [6:0] REG_REV   = 7'h00;
   localparam logic [6:0] REG_STAT  = 7'h01;
   localparam logic [6:0] REG_INTEN = 7'h02;
   localparam logic [6:0] REG_CFG   = 7'h03;
   localparam logic [6:0] REG_SRST  = 7'h06;
   localparam logic [6:0] REG_DATA0 = 7'h07;

   // Arbitrary revision code, not tied to any real part
   localparam logic [15:0] REV_ID = 16'h5A01;

   // Status bit positions
   localparam int ST_FRAME_ERR = 0;
   localparam int ST_IDLE_EXP  = 2;
   localparam int ST_HV_LOSS   = 3;

   // Configuration bit positions and reset value
   localparam int CFG_CRC_EN    = 0;
   localparam int CFG_IDLE_ON   = 2;
   localparam int CFG_IDLE_FULL = 3;
   localparam int CFG_SEL_LSB   = 4;
   localparam int CFG_REF_SEL   = 8;
   localparam int CFG_TRANS_LSB = 12;
   localparam logic [15:0] CFG_RST   = 16'h0001;
   localparam logic [15:0] CFG_WMASK = 16'hFDFF;

   // Soft reset bit positions
   localparam int SR_FULL  = 8;
   localparam int SR_CLEAR = 12;

   // Frame lengths in serial clocks
   localparam logic [5:0] FRAME_LEN_CRC   = 6'h20;
   localparam logic [5:0] FRAME_LEN_PLAIN = 6'h18;
   localparam logic [5:0] HDR_LEN         = 6'h08;

   // Idle watch timebase: one step of the select field is 100 ms
   localparam int CLK_MHZ          = 100;
   localparam int IDLE_STEP_MS     = 100;
   localparam int IDLE_STEP_CYCLES = IDLE_STEP_MS * 1000 * CLK_MHZ;
   localparam int TICK_W           = 24;

   // Frame check code: generator 0x31, processed reflected, start at zero, no final xor
   localparam logic [7:0] CRC_POLY      = 8'h31;
   // Generator 0x31 with its bit order reversed, for low-bit-first shifting
   localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
   localparam logic [7:0] CRC_INIT      = 8'h00;

   localparam int N_CH = 4;

   // Check byte over three bytes taken in order, each byte low bit first
   function automatic logic [7:0] sfc_crc8(input logic [23:0] d);
      logic [7:0] c;
      c = CRC_INIT;
      for (int b = 2; b >= 0; b--) begin
         c = c ^ d[b*8 +: 8];
         for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
         end
      end
      return c;
   endfunction : sfc_crc8

   // Whole state of the block
   typedef struct packed {
      logic [1:0]             cs_s;
      logic [1:0]             sclk_s;
      logic [1:0]             mosi_s;
      logic [1:0]             ld_s;
      logic [1:0]             hv_s;
      logic                   cs_d;
      logic                   sclk_d;
      logic [5:0]             cnt;
      logic [5:0]             fcnt;
      logic [31:0]            shf;
      logic [23:0]            tx;
      logic                   miso;
      logic                   rdy_n;
      logic                   f_crc;
      logic                   f_tmo;
      logic                   f_hv;
      logic [15:0]            inten;
      logic [15:0]            cfg;
      logic [N_CH-1:0][11:0]  data;
      logic [N_CH-1:0][11:0]  latch;
      logic                   active;
      logic [TICK_W-1:0]      tick;
      logic [4:0]             idle;
      logic                   a_wr;
      logic [6:0]             a_idx;
      logic [31:0]            hrdata;
   } sfc_state_t;

endpackage : sfc_pkg

// *** rtl/sfc_core.sv ***
// Serial frame check, idle watch, chain ready, latch load and resets with register slave
// Operation
// - Check byte is an 8-bit cyclic code with generator 0x31.
// - Each byte is processed low bit first, byte order kept, result reflected.
// - Check starts at zero each frame, final value used without xor.
// - Write check covers register number, direction bit and 16-bit payload.
// - Read check byte covers received header plus the 16 returned bits.
// - Frame well-formed: select low, at least 24 or 32 clocks, select high.
// - A frame with a wrong check byte still counts for the idle watch.
// - Idle interval restarts each well-formed frame, length 100 ms to 1.6 s.
// - No well-formed frame before the interval ends sets the expired flag.
// - Expiry with full-reset option restores registers, keeping four named bits.
// - Idle watch off after reset, first interval starts when enabling frame ends.
// - Chain ready goes low on 24th or 32nd serial clock falling edge.
// - Falling load input moves all non-transparent channel data into latches together.
// - While load input is low, channel data flows straight into latches.
// - Transparent channel latch follows a data write at once, any load level.
// - Non-transparent channel latch loads only while the load input is low, from its falling edge on.
// - Block held in reset while the power-on indication is asserted.
// - High supply loss report sets the supply-loss flag.
// - Full soft reset keeps check enable and reference; soft clear zeros data.
// - Hardware reset input restores power-on state and aborts any frame.
// - Frame is number, direction, payload, check byte, most significant first.
// - Frame check enable resets to one.
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps

module sfc_core #(
   parameter int unsigned TICK_CYCLES = sfc_pkg::IDLE_STEP_CYCLES
) (
   // Clock and resets
   input  logic                                 hclk,
   input  logic                                 hresetn,
   input  logic                                 hw_rst_n,
   input  logic                                 por_hold,
   // AHB-Lite register slave
   input  logic                                 hsel,
   input  logic [31:0]                          haddr,
   input  logic [1:0]                           htrans,
   input  logic                                 hwrite,
   input  logic [2:0]                           hsize,
   input  logic [31:0]                          hwdata,
   input  logic                                 hready,
   output logic                                 hreadyout,
   output logic                                 hresp,
   output logic [31:0]                          hrdata,
   // Serial link
   input  logic                                 spi_cs_n,
   input  logic                                 spi_sclk,
   input  logic                                 spi_mosi,
   output logic                                 spi_miso,
   output logic                                 chain_ready_n,
   // Converter side
   input  logic                                 latch_load_n,
   input  logic                                 high_supply_lost,
   output logic [sfc_pkg::N_CH-1:0][11:0]       dac_latch
);
   import sfc_pkg::*;

   sfc_state_t s_r;
   sfc_state_t s_nxt;
   logic [1:0] rst_sync_r;
   logic       rst_n;
   logic       rst_raw_n;

   assign rst_raw_n = hresetn & hw_rst_n & ~por_hold;

   always_ff @(posedge hclk or negedge rst_raw_n) begin
      if (!rst_raw_n) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Register read view
   function automatic logic [15:0] rd_reg(input sfc_state_t s, input logic [6:0] idx);
      logic [15:0] r;
      r = 16'h0000;
      if (idx == REG_REV) begin
         r = REV_ID;
      end else if (idx == REG_STAT) begin
         r[ST_FRAME_ERR] = s.f_crc;
         r[ST_IDLE_EXP]  = s.f_tmo;
         r[ST_HV_LOSS]   = s.f_hv;
      end else if (idx == REG_INTEN) begin
         r = s.inten;
      end else if (idx == REG_CFG) begin
         r = s.cfg;
      end
      for (int i = 0; i < N_CH; i++) begin
         if (idx == REG_DATA0 + 7'(i)) begin
            r = {s.data[i], 4'h0};
         end
      end
      return r;
   endfunction : rd_reg

   // Power-on values except check enable and reference, which both kinds keep; idle kind also keeps the expired flag and its mask bit
   function automatic sfc_state_t reg_defaults(input sfc_state_t s, input logic idle_kind);
      sfc_state_t o;
      o       = s;
      o.cfg   = CFG_RST;
      o.cfg[CFG_CRC_EN]  = s.cfg[CFG_CRC_EN];
      o.cfg[CFG_REF_SEL] = s.cfg[CFG_REF_SEL];
      o.inten = 16'h0000;
      o.inten[ST_IDLE_EXP] = idle_kind & s.inten[ST_IDLE_EXP];
      o.f_crc = 1'b0;
      o.f_hv  = 1'b0;
      o.f_tmo = idle_kind & s.f_tmo;
      o.data  = '0;
      o.latch = '0;
      o.active = 1'b0;
      return o;
   endfunction : reg_defaults

   // Register write; status bits clear on writing one
   function automatic sfc_state_t wr_reg(input sfc_state_t s, input logic [6:0] idx,
                                         input logic [15:0] d);
      sfc_state_t o;
      o = s;
      if (idx == REG_STAT) begin
         o.f_crc = s.f_crc & ~d[ST_FRAME_ERR];
         o.f_tmo = s.f_tmo & ~d[ST_IDLE_EXP];
         o.f_hv  = s.f_hv & ~d[ST_HV_LOSS];
      end else if (idx == REG_INTEN) begin
         o.inten = d;
      end else if (idx == REG_CFG) begin
         o.cfg = d & CFG_WMASK;
      end else if (idx == REG_SRST) begin
         if (d[SR_FULL]) begin
            o = reg_defaults(o, 1'b0);
         end
         if (d[SR_CLEAR]) begin
            o.data  = '0;
            o.latch = '0;
         end
      end
      for (int i = 0; i < N_CH; i++) begin
         if (idx == REG_DATA0 + 7'(i)) begin
            o.data[i] = d[15:4];
         end
      end
      return o;
   endfunction : wr_reg

   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_rise;
   logic [5:0]  need;
   logic        well_formed;
   logic [23:0] body;
   logic        frame_rd;
   logic        crc_ok;
   logic        crc_err;
   logic        spi_wr;
   logic        expire;
   logic [7:0]  hdr;
   logic [15:0] rdata;
   logic [4:0]  idle_len;

   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      // Pin synchronisers, first stage read only by the second
      s_nxt.cs_s   = {s_r.cs_s[0], spi_cs_n};
      s_nxt.sclk_s = {s_r.sclk_s[0], spi_sclk};
      s_nxt.mosi_s = {s_r.mosi_s[0], spi_mosi};
      s_nxt.ld_s   = {s_r.ld_s[0], latch_load_n};
      s_nxt.hv_s   = {s_r.hv_s[0], high_supply_lost};
      s_nxt.cs_d   = s_r.cs_s[1];
      s_nxt.sclk_d = s_r.sclk_s[1];
      sclk_rise = s_r.sclk_s[1] & ~s_r.sclk_d;
      sclk_fall = ~s_r.sclk_s[1] & s_r.sclk_d;
      cs_rise   = s_r.cs_s[1] & ~s_r.cs_d;
      need = s_r.cfg[CFG_CRC_EN] ? FRAME_LEN_CRC : FRAME_LEN_PLAIN;
      hdr   = {s_r.shf[6:0], s_r.mosi_s[1]};
      rdata = rd_reg(s_r, hdr[7:1]);

      // Serial shift, chain ready and read return
      if (s_r.cs_s[1]) begin
         s_nxt.cnt   = 6'h00;
         s_nxt.fcnt  = 6'h00;
         s_nxt.tx    = 24'h000000;
         s_nxt.miso  = 1'b0;
         s_nxt.rdy_n = 1'b1;
      end else begin
         if (sclk_rise && s_r.cnt != 6'h3F) begin
            if (s_r.cnt < need) begin
               s_nxt.shf = {s_r.shf[30:0], s_r.mosi_s[1]};
            end
            s_nxt.cnt = s_r.cnt + 6'h01;
            if (s_r.cnt == HDR_LEN - 6'h01) begin
               s_nxt.tx = {rdata, sfc_crc8({hdr, rdata})};
            end
         end
         if (sclk_fall && s_r.fcnt != 6'h3F) begin
            s_nxt.fcnt = s_r.fcnt + 6'h01;
            if (s_r.fcnt + 6'h01 == need) begin
               s_nxt.rdy_n = 1'b0;
            end
            if (s_r.cnt >= HDR_LEN) begin
               s_nxt.miso = s_r.tx[23];
               s_nxt.tx   = {s_r.tx[22:0], 1'b0};
            end
         end
      end

      well_formed = cs_rise && (s_r.cnt >= need);
      body     = s_r.cfg[CFG_CRC_EN] ? s_r.shf[31:8] : s_r.shf[23:0];
      frame_rd = body[16];
      crc_ok   = !s_r.cfg[CFG_CRC_EN] || (sfc_crc8(body) == s_r.shf[7:0]);
      spi_wr   = well_formed && !frame_rd && crc_ok;
      crc_err  = well_formed && !frame_rd && !crc_ok;

      // Bus address phase and read data
      s_nxt.a_wr  = hsel & htrans[1] & hready & hwrite;
      s_nxt.a_idx = (haddr[31:8] == 24'h000000) ? {1'b0, haddr[7:2]} : 7'h7F;
      if (hsel && htrans[1] && hready && !hwrite) begin
         s_nxt.hrdata = {16'h0000, rd_reg(s_r, s_nxt.a_idx)};
      end
      if (s_r.a_wr) begin
         s_nxt = wr_reg(s_nxt, s_r.a_idx, hwdata[15:0]);
      end
      if (spi_wr) begin
         s_nxt = wr_reg(s_nxt, body[23:17], body[15:0]);
      end

      idle_len = {1'b0, s_nxt.cfg[CFG_SEL_LSB +: 4]} + 5'h01;
      expire   = 1'b0;
      if (well_formed) begin
         s_nxt.tick = '0;
         s_nxt.idle = 5'h00;
         s_nxt.active = s_nxt.cfg[CFG_IDLE_ON];
      end else if (!s_nxt.cfg[CFG_IDLE_ON]) begin
         s_nxt.active = 1'b0;
      end else if (s_r.active) begin
         if (s_r.tick == TICK_W'(TICK_CYCLES - 1)) begin
            s_nxt.tick = '0;
            s_nxt.idle = s_r.idle + 5'h01;
            if (s_r.idle + 5'h01 >= idle_len) begin
               expire       = 1'b1;
               s_nxt.active = 1'b0;
            end
         end else begin
            s_nxt.tick = s_r.tick + TICK_W'(1);
         end
      end
      if (expire && s_nxt.cfg[CFG_IDLE_FULL]) begin
         s_nxt = reg_defaults(s_nxt, 1'b1);
      end

      // Event sets win over clears
      s_nxt.f_tmo = s_nxt.f_tmo | expire;
      s_nxt.f_crc = s_nxt.f_crc | crc_err;
      s_nxt.f_hv  = s_nxt.f_hv | s_r.hv_s[1];

      // load on falling edge, pass while low, transparent, hold
      for (int i = 0; i < N_CH; i++) begin
         if (s_nxt.cfg[CFG_TRANS_LSB + i] || !s_r.ld_s[1]) begin
            s_nxt.latch[i] = s_nxt.data[i];
         end
      end
   end

   // State register
   always_ff @(posedge hclk or negedge rst_n) begin
      if (!rst_n) begin
         s_r        <= '0;
         s_r.cfg    <= CFG_RST;
         s_r.rdy_n  <= 1'b1;
         s_r.cs_s   <= 2'b11;
         s_r.cs_d   <= 1'b1;
         s_r.ld_s   <= 2'b11;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign hrdata        = s_r.hrdata;
   assign spi_miso      = s_r.miso;
   assign chain_ready_n = s_r.rdy_n;
   assign dac_latch     = s_r.latch;

   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!rst_n);

   property p_crc_vec;
      sfc_crc8(24'h04F000) == 8'h07 && sfc_crc8(24'h1053FA) == 8'h62;
   endproperty
   a_crc_vec: assert property (p_crc_vec) else $error("check byte vector mismatch");

   property p_restart;
      well_formed |=> (s_r.tick == '0) && (s_r.idle == 5'h00);
   endproperty
   a_restart: assert property (p_restart) else $error("idle interval not restarted");

   property p_expire_cause;
      $rose(s_r.f_tmo) |-> $past(s_r.active) && $past(s_r.tick) == TICK_W'(TICK_CYCLES - 1);
   endproperty
   a_expire_cause: assert property (p_expire_cause) else $error("expiry without interval");

   property p_rdy_edge;
      $fell(s_r.rdy_n) |-> $past(sclk_fall) && $past(s_r.fcnt) == need - 6'h01;
   endproperty
   a_rdy_edge: assert property (p_rdy_edge) else $error("chain ready at wrong edge");

   property p_bad_write;
      crc_err |=> s_r.f_crc ##0 $stable(s_r.cfg);
   endproperty
   a_bad_write: assert property (p_bad_write) else $error("bad write not flagged");

   property p_transparent;
      s_r.cfg[CFG_TRANS_LSB] ##1 s_r.cfg[CFG_TRANS_LSB] |-> s_r.latch[0] == $past(s_nxt.data[0]);
   endproperty
   a_transparent: assert property (p_transparent) else $error("transparent latch lag");

   property p_pass_low;
      !s_r.ld_s[1] |=> s_r.latch[1] == s_r.data[1];
   endproperty
   a_pass_low: assert property (p_pass_low) else $error("latch not following while low");

   property p_hold_high;
      !s_nxt.cfg[CFG_TRANS_LSB + 2] && s_r.ld_s[1] && s_nxt.data[2] != '0 && s_r.cfg[CFG_TRANS_LSB + 2] == 1'b0
         |-> s_nxt.latch[2] == s_r.latch[2] || s_nxt.latch[2] == '0;
   endproperty
   a_hold_high: assert property (p_hold_high) else $error("latch moved without load edge");

   property p_supply;
      s_r.hv_s[1] |=> s_r.f_hv;
   endproperty
   a_supply: assert property (p_supply) else $error("supply loss not flagged");

   property p_frame_wf;
      well_formed;
   endproperty
   c_frame_wf: cover property (p_frame_wf);

   property p_expiry;
      expire;
   endproperty
   c_expiry: cover property (p_expiry);

   property p_read;
      well_formed && frame_rd;
   endproperty
   c_read: cover property (p_read);

   property p_crc_err;
      crc_err;
   endproperty
   c_crc_err: cover property (p_crc_err);

endmodule : sfc_core

// *** dv/sfc_spi_host.sv ***
// Serial host model that drives whole frames into the block
`timescale 1ns/10ps

module sfc_spi_host (
   // Lines driven toward the block
   output logic      cs_n,
   output logic      sclk,
   output logic      mosi,
   // Lines returned by the block
   input  wire logic miso,
   input  wire logic rdy_n
);
   logic [25:0] res;
   event        done;

   // Select idles high and the clock stands low between frames
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end

   // One frame of n bits; the odd start offset keeps sclk off the hclk grid
   // most significant bit first
   task automatic xfer(input logic [31:0] w, input int n, input bit keep);
      logic [31:0] rx;
      logic        pre;
      rx = 32'h0;
      pre = 1'b1;
      cs_n <= 1'b0;
      #73;
      for (int i = n - 1; i >= 0; i--) begin
         mosi = w[i];
         #80 sclk = 1'b1;
         rx = {rx[30:0], miso};
         if (i == 0) pre = rdy_n;
         #80 sclk = 1'b0;
      end
      #80;
      // ready low before the next device's first falling edge
      res = {pre, rdy_n, keep ? rx[23:0] : 24'h0};
      cs_n = 1'b1;
      // Released data line shows the inverse of its last value
      mosi = ~mosi;
      #200;
      -> done;
   endtask : xfer
endmodule : sfc_spi_host

// *** dv/testbench.sv ***
// Self-checking bench for the serial control block
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module testbench;
   import sfc_pkg::*;
   localparam int TICKS = 1000;
   logic                  hclk, hresetn, hw_rst_n, por_hold, hsel, hwrite, hreadyout, hresp;
   logic [31:0]           haddr, hwdata, hrdata;
   logic [1:0]            htrans;
   logic                  spi_cs_n, spi_sclk, spi_mosi, spi_miso, chain_ready_n;
   logic                  latch_load_n, high_supply_lost, rd_dp;
   logic [N_CH-1:0][11:0] dac_latch, le;
   logic [47:0]           exp_q[$];
   logic [11:0]           chv[4];
   logic [15:0]           v;
   int                    failures, samples_checked;
   event                  lat_ev;

   sfc_core #(.TICK_CYCLES(TICKS)) u_sfc_core (.hclk(hclk), .hresetn(hresetn),
      .hw_rst_n(hw_rst_n), .por_hold(por_hold), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .chain_ready_n(chain_ready_n), .latch_load_n(latch_load_n),
      .high_supply_lost(high_supply_lost), .dac_latch(dac_latch));

   sfc_spi_host u_sfc_spi_host (.cs_n(spi_cs_n), .sclk(spi_sclk), .mosi(spi_mosi),
      .miso(spi_miso), .rdy_n(chain_ready_n));

   // Clock
   always #5 hclk = ~hclk;

   // Check byte worked out bit by bit, low bit of each byte first
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 16; i >= 0; i -= 8) begin
         for (int k = 0; k < 8; k++) begin
            c = (c >> 1) ^ ((c[0] ^ d[i + k]) ? 8'h8C : 8'h00);
         end
      end
      return c;
   endfunction : crc8

   // Oldest note against a result
   task automatic chk(input logic [47:0] got);
      logic [47:0] e;
      e = 48'h0;
      if (exp_q.size() == 0) failures++;
      else e = exp_q.pop_front();
      `CHK(got, e)
   endtask : chk

   // Result watchers
   always @(posedge hclk) if (rd_dp === 1'b1 && hreadyout === 1'b1) chk({15'h0, hresp, hrdata});
   always @(u_sfc_spi_host.done) chk({22'h0, u_sfc_spi_host.res});
   always @(lat_ev) chk(dac_latch);

   // Single bus transfer: address phase, then data phase
   task automatic bus(input logic [6:0] idx, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {23'h0, idx, 2'b00};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_dp <= ~w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask : bus

   task automatic rd(input logic [6:0] idx, input logic [15:0] e);
      exp_q.push_back({32'h0, e});
      bus(idx, 1'b0, 32'h0);
   endtask : rd

   task automatic wr(input logic [6:0] idx, input logic [15:0] d);
      bus(idx, 1'b1, {16'h0, d});
      repeat (2) @(posedge hclk);
   endtask : wr

   task automatic spi_wr(input logic [6:0] idx, input logic [15:0] d, input bit on, input bit bad);
      logic [23:0] h;
      h = {idx, 1'b0, d};
      exp_q.push_back({22'h0, 2'b10, 24'h0});
      if (on) u_sfc_spi_host.xfer({h, crc8(h) ^ {7'h0, bad}}, 32, 1'b0);
      else u_sfc_spi_host.xfer({8'h0, h}, 24, 1'b0);
      @(posedge hclk);
   endtask : spi_wr

   task automatic spi_rd(input logic [6:0] idx, input logic [15:0] d);
      exp_q.push_back({22'h0, 2'b10, d, crc8({idx, 1'b1, d})});
      u_sfc_spi_host.xfer({idx, 1'b1, 24'h0}, 32, 1'b1);
      @(posedge hclk);
   endtask : spi_rd

   task automatic lat();
      exp_q.push_back(le);
      repeat (5) @(posedge hclk);
      #1 -> lat_ev;
      @(posedge hclk);
   endtask : lat

   task automatic final_report();
      if (failures == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   // Watchdog
   initial begin
      #600_000;
      failures++;
      final_report();
   end

   // Main sequence
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hw_rst_n = 1'b1;
      por_hold = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      latch_load_n = 1'b1;
      high_supply_lost = 1'b0;
      rd_dp = 1'b0;
      failures = 0;
      samples_checked = 0;
      le = '0;
      void'($urandom(24));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (5) @(posedge hclk);
      // Reset values and unmapped places
      rd(REG_REV, REV_ID);
      rd(REG_CFG, CFG_RST);
      rd(7'h04, 16'h0000);
      rd(7'h0B, 16'h0000);
      // Frames with known check bytes
      exp_q.push_back({22'h0, 2'b10, 24'h0});
      u_sfc_spi_host.xfer(32'h04F0_0007, 32, 1'b0);
      exp_q.push_back({22'h0, 2'b10, 24'h0});
      u_sfc_spi_host.xfer(32'h1053_FA62, 32, 1'b0);
      @(posedge hclk);
      rd(REG_INTEN, 16'hF000);
      rd(7'h08, 16'h53F0);
      // Random channel data over the link, read back with its check byte
      for (int c = 0; c < 4; c++) begin
         v = 16'($urandom()) & 16'hFFF0;
         chv[c] = v[15:4];
         spi_wr(7'(REG_DATA0 + c), v, 1'b1, 1'b0);
         spi_rd(7'(REG_DATA0 + c), v);
      end
      // Bad check byte is dropped and flagged
      spi_wr(REG_DATA0, 16'h1110, 1'b1, 1'b1);
      rd(REG_DATA0, {chv[0], 4'h0});
      rd(REG_STAT, 16'h0001);
      wr(REG_STAT, 16'h0001);
      // Frame one bit short: ignored, chain never handed on
      v = 16'h4440;
      exp_q.push_back({22'h0, 2'b11, 24'h0});
      u_sfc_spi_host.xfer({REG_DATA0, 1'b0, v, crc8({REG_DATA0, 1'b0, v})} >> 1, 31, 1'b0);
      @(posedge hclk);
      rd(REG_DATA0, {chv[0], 4'h0});
      // Unchecked 24-bit frame
      wr(REG_CFG, 16'h0000);
      spi_wr(7'h09, 16'hABC0, 1'b0, 1'b0);
      chv[2] = 12'hABC;
      rd(7'h09, 16'hABC0);
      // Channel 0 transparent, the rest wait for the load edge
      wr(REG_CFG, 16'h1001);
      wr(REG_DATA0, 16'hAAA0);
      wr(7'h08, 16'h5550);
      chv[0] = 12'hAAA;
      chv[1] = 12'h555;
      le[0] = 12'hAAA;
      lat();
      latch_load_n <= 1'b0;
      le = {chv[3], chv[2], chv[1], chv[0]};
      lat();
      wr(7'h08, 16'h1230);
      le[1] = 12'h123;
      lat();
      latch_load_n <= 1'b1;
      // Let the raised load input pass its synchroniser before the write
      repeat (3) @(posedge hclk);
      wr(7'h08, 16'h7770);
      lat();
      // Soft clear, then soft full reset
      wr(REG_SRST, 16'h1000);
      le = '0;
      lat();
      rd(7'h08, 16'h0000);
      wr(REG_CFG, 16'h1101);
      wr(REG_SRST, 16'h0100);
      rd(REG_CFG, 16'h0101);
      rd(REG_SRST, 16'h0000);
      // Supply loss flag
      high_supply_lost <= 1'b1;
      repeat (5) @(posedge hclk);
      rd(REG_STAT, 16'h0008);
      high_supply_lost <= 1'b0;
      // Monitor low must clear the synchroniser, else the set wins over the clear
      repeat (3) @(posedge hclk);
      wr(REG_STAT, 16'h0008);
      // Idle watch restarted by a frame with a bad check byte, then expiry
      spi_wr(REG_CFG, 16'h0005, 1'b1, 1'b0);
      repeat (200) @(posedge hclk);
      spi_wr(REG_DATA0, 16'h2220, 1'b1, 1'b1);
      repeat (700) @(posedge hclk);
      rd(REG_STAT, 16'h0001);
      repeat (600) @(posedge hclk);
      rd(REG_STAT, 16'h0005);
      // Expiry with full reset keeps the named bits only
      wr(REG_STAT, 16'h0005);
      wr(REG_INTEN, 16'hF004);
      wr(REG_DATA0, 16'h3330);
      spi_wr(REG_CFG, 16'h011D, 1'b1, 1'b0);
      repeat (1500) @(posedge hclk);
      rd(REG_STAT, 16'h0000);
      repeat (1000) @(posedge hclk);
      rd(REG_CFG, 16'h0101);
      rd(REG_INTEN, 16'h0004);
      rd(REG_STAT, 16'h0004);
      rd(REG_DATA0, 16'h0000);
      // Reset pin, then power-on hold
      for (int k = 0; k < 2; k++) begin
         wr(REG_CFG, 16'h0000);
         if (k == 0) hw_rst_n <= 1'b0;
         else por_hold <= 1'b1;
         repeat (3) @(posedge hclk);
         hw_rst_n <= 1'b1;
         por_hold <= 1'b0;
         repeat (5) @(posedge hclk);
         rd(REG_CFG, CFG_RST);
      end
      repeat (2) @(posedge hclk);
      if (exp_q.size() != 0) failures++;
      final_report();
   end
endmodule : testbench
